// >>> hdl/rsw_supervisor.sv
/*
 * Supervisor end: four reset channels and the watchdog of channel 1.
 * Assumes comparator results arrive as digital levels, high meaning
 * above threshold, and that hresetn models supply power-down.
 */
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
// Functional notes
// - release only after the selected delay
// - assert reset immediately, no delay
// - primary: manual low or rail low
// - second channel follows its rail
// - fourth channel is a window monitor
// - delay is long, short or programmable
// - watchdog counts only after primary release
// - any kick edge restarts the count
// - timeout nominally 600 ms
// - no kick in time raises fault
// - fault stays latched despite kicks
// - fault clears only on primary reset
// - fault may feed the manual input
// - manual input must be driven high
// - resets and manual sources may wire-OR
`timescale 1ns/100ps
module rsw_supervisor
    import rsw_pkg::*;
#(
    parameter int CW        = RSW_CNT_W,
    parameter int LONG_CYC  = RSW_LONG_DELAY_CYC,
    parameter int SHORT_CYC = RSW_SHORT_DELAY_CYC,
    parameter int TMO_CYC   = RSW_TMO_CYC
) (
    // clock and power-on reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // comparator levels, high is above threshold
    input  wire logic                 rail1_sense,
    input  wire logic                 rail2_sense,
    input  wire logic                 rail3_sense,
    input  wire logic                 window_low_sense,
    input  wire logic                 window_high_sense,
    // per-channel delay straps
    input  wire rsw_delay_e [3:0]     delay_select_pin,
    input  wire logic [3:0][CW-1:0]   prog_delay_cycles,
    // pins towards the processor
    rsw_link_if.device                link
);

    // synchronised inputs
    localparam int NSYNC = 7;

    // input vector ordering
    localparam int S_R1   = 0;
    localparam int S_R2   = 1;
    localparam int S_R3   = 2;
    localparam int S_WLO  = 3;
    localparam int S_WHI  = 4;
    localparam int S_MN   = 5;
    localparam int S_KICK = 6;

    // terminal counts
    localparam logic [CW-1:0] LONG_T  = CW'(LONG_CYC);
    localparam logic [CW-1:0] SHORT_T = CW'(SHORT_CYC);
    localparam logic [CW-1:0] TMO_END = CW'(TMO_CYC - 1);

    // input path
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic             kick_prev;
    logic             kick_edge;

    logic [3:0]       assert_cond;
    logic [3:0]       ch_active;

    // watchdog
    rsw_wd_e          wd_state;
    rsw_wd_e          next_wd_state;
    logic [CW-1:0]    wd_count;
    logic             wd_expired;
    logic             fault_hold;

    // gather the asynchronous levels
    assign raw_in = {link.watchdog_kick_in, link.manual_reset_in_n,
                     window_high_sense, window_low_sense,
                     rail3_sense, rail2_sense, rail1_sense};

    // two-flop synchroniser; first stage feeds only the second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    // previous kick level for edge detection
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_prev <= 1'b0;
        end else begin
            kick_prev <= sync_b[S_KICK];
        end
    end

    // both polarities count as a kick
    assign kick_edge = sync_b[S_KICK] ^ kick_prev;

    // primary: manual low or rail low asserts
    assign assert_cond[0] = ~sync_b[S_MN] | ~sync_b[S_R1];
    // second and third follow their own rail
    assign assert_cond[1] = ~sync_b[S_R2];
    assign assert_cond[2] = ~sync_b[S_R3];
    // window: under the low edge or over the high edge
    assign assert_cond[3] = ~sync_b[S_WLO] | sync_b[S_WHI];

    // one delay channel each, strapped independently
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ch
            rsw_channel #(
                .CW           (CW)
            ) u_ch (
                .hclk         (hclk),
                .hresetn      (hresetn),
                .assert_cond  (assert_cond[gi]),
                .delay_mode   (delay_select_pin[gi]),
                .prog_cycles  (prog_delay_cycles[gi]),
                .long_cycles  (LONG_T),
                .short_cycles (SHORT_T),
                .reset_active (ch_active[gi])
            );
        end
    endgenerate

    // timeout reached on the last counted cycle
    assign wd_expired = (wd_count == TMO_END);

    // watchdog sequencing
    always_comb begin
        next_wd_state = wd_state;
        unique case (wd_state)
            RSW_WD_HOLD: begin
                // countdown waits for primary release
                if (!ch_active[0]) begin
                    next_wd_state = RSW_WD_RUN;
                end
            end
            RSW_WD_RUN: begin
                if (ch_active[0]) begin
                    next_wd_state = RSW_WD_HOLD;
                end else if (wd_expired && !kick_edge) begin
                    next_wd_state = RSW_WD_FAULT;
                end
            end
            RSW_WD_FAULT: begin
                // kicks are ignored here; only primary reset exits
                if (ch_active[0]) begin
                    next_wd_state = RSW_WD_HOLD;
                end
            end
            default: begin
                // illegal code
                next_wd_state = RSW_WD_HOLD;
            end
        endcase
    end

    // state register; power-down lands in hold
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_state <= RSW_WD_HOLD;
        end else begin
            wd_state <= next_wd_state;
        end
    end

    // timeout counter, cleared by any kick edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_count <= '0;
        end else if (wd_state != RSW_WD_RUN || kick_edge) begin
            wd_count <= '0;
        end else if (!wd_expired) begin
            wd_count <= wd_count + 1'b1;
        end
    end

    // fault latch, registered so the pin never glitches
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_hold <= 1'b0;
        end else begin
            fault_hold <= (next_wd_state == RSW_WD_FAULT);
        end
    end

    // open-drain pins drive low only; channel state is already a flop
    assign link.channel_reset_o  = 4'h0;
    assign link.channel_reset_oe = ch_active;
    // fault pin
    assign link.watchdog_fault_o  = 1'b0;
    assign link.watchdog_fault_oe = fault_hold;

endmodule

// >>> hdl/rsw_pkg.sv
/*
 * Shared constants of the rail supervisor watchdog: timing counts,
 * delay-select encodings, watchdog states and controller register map.
 * Assumes a single 25 MHz clock shared by both ends.
 */
package rsw_pkg;

    // clock rate and derived cycles per millisecond
    localparam int RSW_CLK_HZ     = 25_000_000;
    localparam int RSW_CYC_PER_MS = RSW_CLK_HZ / 1000;

    // documented times in milliseconds
    localparam int RSW_LONG_DELAY_MS  = 300;
    localparam int RSW_SHORT_DELAY_MS = 20;
    localparam int RSW_TMO_MIN_MS     = 450;
    localparam int RSW_TMO_NOM_MS     = 600;
    localparam int RSW_TMO_MAX_MS     = 750;

    // cycle counts; all are whole numbers at 25 MHz
    localparam int RSW_LONG_DELAY_CYC  = RSW_LONG_DELAY_MS * RSW_CYC_PER_MS;
    localparam int RSW_SHORT_DELAY_CYC = RSW_SHORT_DELAY_MS * RSW_CYC_PER_MS;
    localparam int RSW_TMO_CYC         = RSW_TMO_NOM_MS * RSW_CYC_PER_MS;

    // counter width that holds the longest window bound
    localparam int RSW_CNT_W = 25;

    // release delay choice per channel
    typedef enum logic [1:0] {
        RSW_DLY_LONG  = 2'h0,
        RSW_DLY_SHORT = 2'h1,
        RSW_DLY_PROG  = 2'h2,
        RSW_DLY_RSVD  = 2'h3
    } rsw_delay_e;

    // watchdog states, gray along hold -> run -> fault
    typedef enum logic [1:0] {
        RSW_WD_HOLD  = 2'h0,
        RSW_WD_RUN   = 2'h1,
        RSW_WD_FAULT = 2'h3
    } rsw_wd_e;

    // controller register byte offsets
    localparam logic [7:0] RSW_CTRL_OFS     = 8'h00;
    localparam logic [7:0] RSW_KICK_OFS     = 8'h04;
    localparam logic [7:0] RSW_STATUS_OFS   = 8'h08;
    localparam logic [7:0] RSW_IRQ_STAT_OFS = 8'h0c;
    localparam logic [7:0] RSW_IRQ_MASK_OFS = 8'h10;

    // field positions and reset values
    localparam int         RSW_CTRL_MN_BIT     = 0;
    localparam int         RSW_CTRL_LEGACY_BIT = 1;
    localparam int         RSW_EVT_FLT_BIT     = 4;
    localparam logic [1:0] RSW_CTRL_RST        = 2'h0;
    localparam logic [4:0] RSW_IRQ_RST         = 5'h00;

endpackage

// >>> hdl/rsw_link_if.sv
/*
 * Pins between the supervisor and the processor-side controller.
 * Open-drain pins are resolved here with board pull-ups assumed.
 */
`timescale 1ns/100ps
interface rsw_link_if;

    // open-drain reset outputs, one per channel
    logic [3:0] channel_reset_o;
    logic [3:0] channel_reset_oe;
    logic [3:0] channel_reset_out_n;
    logic       primary_reset_out_n;
    logic       second_reset_out_n;
    // open-drain watchdog fault output
    logic       watchdog_fault_o;
    logic       watchdog_fault_oe;
    logic       watchdog_fault_out_n;
    // manual reset line, shared open-drain
    logic       manual_reset_o;
    logic       manual_reset_oe;
    logic       legacy_link;
    logic       manual_reset_in_n;
    // push-pull kick
    logic       watchdog_kick_in;

    // each reset pin has its own pull-up
    assign channel_reset_out_n  = ~(channel_reset_oe & ~channel_reset_o);
    assign primary_reset_out_n  = channel_reset_out_n[0];
    assign second_reset_out_n   = channel_reset_out_n[1];
    assign watchdog_fault_out_n = ~(watchdog_fault_oe & ~watchdog_fault_o);

    // one pull-up keeps the line high; either source may pull it low
    // the fault joins the line only when the legacy link is on
    assign manual_reset_in_n = ~((manual_reset_oe & ~manual_reset_o)
                               | (legacy_link & watchdog_fault_oe & ~watchdog_fault_o));

    modport device (
        output channel_reset_o,
        output channel_reset_oe,
        output watchdog_fault_o,
        output watchdog_fault_oe,
        input  manual_reset_in_n,
        input  watchdog_kick_in
    );

    modport host (
        output manual_reset_o,
        output manual_reset_oe,
        output legacy_link,
        output watchdog_kick_in,
        input  channel_reset_out_n,
        input  primary_reset_out_n,
        input  second_reset_out_n,
        input  watchdog_fault_out_n,
        input  manual_reset_in_n
    );

endinterface

// >>> hdl/rsw_channel.sv
/*
 * One supervisor channel: immediate assert, counted release delay.
 * Assumes a synchronised assert condition and strap inputs.
 */
`timescale 1ns/100ps
module rsw_channel
    import rsw_pkg::*;
#(
    parameter int CW = RSW_CNT_W
) (
    // clock and reset
    input  wire logic          hclk,
    input  wire logic          hresetn,
    // condition and delay choice
    input  wire logic          assert_cond,
    input  wire rsw_delay_e    delay_mode,
    input  wire logic [CW-1:0] prog_cycles,
    input  wire logic [CW-1:0] long_cycles,
    input  wire logic [CW-1:0] short_cycles,
    // channel state
    output logic               reset_active
);

    logic [CW-1:0] terminal;
    logic [CW-1:0] count;
    logic          done;

    // terminal count from the strap; an unused code falls back to short
    always_comb begin
        unique case (delay_mode)
            RSW_DLY_LONG:  terminal = long_cycles;
            RSW_DLY_PROG:  terminal = prog_cycles;
            default:       terminal = short_cycles;
        endcase
    end

    // a zero terminal still costs one cycle, never a stuck reset
    assign done = ({1'b0, count} + {{CW{1'b0}}, 1'b1}) >= {1'b0, terminal};

    // counter restarts while asserting, runs only while waiting
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (assert_cond || !reset_active) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    // assert at once, release at terminal count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reset_active <= 1'b1;
        end else if (assert_cond) begin
            reset_active <= 1'b1;
        end else if (reset_active && done) begin
            reset_active <= 1'b0;
        end
    end

endmodule

// >>> hdl/rsw_host.sv
/*
 * Controller end: drives manual reset and kick from AHB-Lite registers,
 * watches reset and fault pins, and raises one interrupt.
 * Assumes a single slave on the bus, so hreadyout is the bus hready.
 */
`timescale 1ns/100ps
module rsw_host
    import rsw_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // interrupt
    output logic             irq,
    // pins towards the supervisor
    rsw_link_if.host         link
);

    logic [1:0]  ctrl;
    logic        kick_level;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    logic [4:0]  pins_asserted;
    logic [4:0]  pins_prev;
    logic [4:0]  evt;
    logic        ap_take;
    logic        dp_write;
    logic [7:0]  dp_addr;
    logic        rd_clear;
    logic [31:0] rd_mux;

    // active-high view of channel resets and fault
    assign pins_asserted = {~link.watchdog_fault_out_n, ~link.channel_reset_out_n};
    assign evt           = pins_asserted & ~pins_prev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_prev <= 5'h00;
        end else begin
            pins_prev <= pins_asserted;
        end
    end

    // address phase accepted; hsize ignored, word transfers only
    assign ap_take  = hsel & hready & htrans[1];
    assign rd_clear = ap_take & ~hwrite & (haddr[7:0] == RSW_IRQ_STAT_OFS);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= ap_take & hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    // read mux; unmapped words read zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (haddr[7:0])
            RSW_CTRL_OFS:     rd_mux = {30'h0, ctrl};
            RSW_KICK_OFS:     rd_mux = {31'h0, kick_level};
            RSW_STATUS_OFS:   rd_mux = {26'h0, ~link.manual_reset_in_n, pins_asserted};
            RSW_IRQ_STAT_OFS: rd_mux = {27'h0, irq_stat};
            RSW_IRQ_MASK_OFS: rd_mux = {27'h0, irq_mask};
            default:          rd_mux = 32'h0000_0000;
        endcase
    end

    // read data captured in the address phase, shown in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap_take && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    // control and mask writes in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl     <= RSW_CTRL_RST;
            irq_mask <= RSW_IRQ_RST;
        end else if (dp_write) begin
            if (dp_addr == RSW_CTRL_OFS) begin
                ctrl <= hwdata[1:0];
            end
            if (dp_addr == RSW_IRQ_MASK_OFS) begin
                irq_mask <= hwdata[4:0];
            end
        end
    end

    // any write to the kick word flips the line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_level <= 1'b0;
        end else if (dp_write && dp_addr == RSW_KICK_OFS) begin
            kick_level <= ~kick_level;
        end
    end

    // sticky events, read clears; a new event beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= RSW_IRQ_RST;
        end else begin
            irq_stat <= (irq_stat & {5{~rd_clear}}) | evt;
        end
    end

    assign irq       = |(irq_stat & irq_mask);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // manual line pulled low on request, released otherwise
    assign link.manual_reset_o  = 1'b0;
    assign link.manual_reset_oe = ctrl[RSW_CTRL_MN_BIT];
    assign link.legacy_link      = ctrl[RSW_CTRL_LEGACY_BIT];
    assign link.watchdog_kick_in = kick_level;

endmodule

// >>> testbench/rsw_chk.sv
/*
 * Checker: timing properties on the supervisor-to-controller link.
 * Assumes the testbench instantiates it beside the link interface.
 */
`timescale 1ns/100ps
module rsw_chk #(
    parameter int TMO_CYC = 300
) (
    // clock and reset
    input wire logic       hclk,
    input wire logic       hresetn,
    // link pins
    input wire logic [3:0] channel_reset_oe,
    input wire logic       watchdog_fault_oe,
    input wire logic       manual_reset_in_n,
    input wire logic       watchdog_kick_in
);
    logic        kick_q;
    logic [31:0] quiet;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // last kick level seen on the pin
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= watchdog_kick_in;
        end
    end

    // cycles released with no kick edge; sync lag only adds slack
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= '0;
        end else if (channel_reset_oe[0] || (watchdog_kick_in != kick_q)) begin
            quiet <= '0;
        end else begin
            quiet <= quiet + 32'h1;
        end
    end

    a_manual_low: assert property (
        !manual_reset_in_n [*4] |-> channel_reset_oe[0])
        else $error("primary reset not asserted by manual input");
    a_primary_hold: assert property (
        $rose(manual_reset_in_n) && channel_reset_oe[0] |=> channel_reset_oe[0] [*8])
        else $error("primary reset released without delay");
    a_release_gap: assert property (
        $fell(channel_reset_oe[0]) |-> $past(manual_reset_in_n, 16))
        else $error("primary released too soon after manual input");
    a_second_hold: assert property (
        $rose(channel_reset_oe[1]) |=> channel_reset_oe[1] [*8])
        else $error("second channel reset too short");
    a_window_hold: assert property (
        $rose(channel_reset_oe[3]) |=> channel_reset_oe[3] [*8])
        else $error("window channel reset too short");
    a_no_fault_held: assert property (
        channel_reset_oe[0] |-> !$rose(watchdog_fault_oe))
        else $error("fault raised while primary asserted");
    a_fault_not_early: assert property (
        $rose(watchdog_fault_oe) |-> quiet >= TMO_CYC)
        else $error("watchdog fault before timeout");
    a_fault_in_time: assert property (
        quiet == TMO_CYC + 8 |-> watchdog_fault_oe)
        else $error("watchdog fault missing after timeout");
    a_fault_latched: assert property (
        watchdog_fault_oe && !channel_reset_oe[0] |=> watchdog_fault_oe || channel_reset_oe[0])
        else $error("watchdog fault dropped without primary reset");
    a_fault_clears: assert property (
        $fell(watchdog_fault_oe) |-> channel_reset_oe[0])
        else $error("watchdog fault cleared without primary reset");

    c_fault: cover property ($rose(watchdog_fault_oe));
    c_release: cover property ($fell(channel_reset_oe[0]));
    c_kick: cover property (watchdog_kick_in != kick_q);
endmodule

// >>> testbench/rail_supervisor_watchdog_tb.sv
/*
 * Testbench: supervisor and controller joined by the link interface.
 * Assumes a single clock; software side reached over AHB-Lite.
 */
`timescale 1ns/100ps
module rail_supervisor_watchdog_tb
    import rsw_pkg::*;
;
    localparam int LONG = 200;
    localparam int SHORT = 20;
    localparam int TMO = 300;
    localparam int LIMIT = 20000;
    localparam int TDLY [4] = '{20, 200, 30, 40};

    logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic                      rail1_sense, rail2_sense, rail3_sense;
    logic                      window_low_sense, window_high_sense;
    rsw_delay_e [3:0]          dsel;
    logic [3:0][RSW_CNT_W-1:0] prog;
    logic [31:0]               haddr, hwdata, hrdata, rd;
    logic [1:0]                htrans;
    logic [2:0]                hsize;
    int                        n_errors, checked, cyc, t0, d;

    rsw_link_if link ();

    rsw_supervisor #(.LONG_CYC(LONG), .SHORT_CYC(SHORT), .TMO_CYC(TMO)) i_rsw_supervisor (
        .hclk(hclk), .hresetn(hresetn), .rail1_sense(rail1_sense),
        .rail2_sense(rail2_sense), .rail3_sense(rail3_sense),
        .window_low_sense(window_low_sense), .window_high_sense(window_high_sense),
        .delay_select_pin(dsel), .prog_delay_cycles(prog), .link(link));

    rsw_host i_rsw_host (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));

    rsw_chk #(.TMO_CYC(TMO)) i_rsw_chk (
        .hclk(hclk), .hresetn(hresetn), .channel_reset_oe(link.channel_reset_oe),
        .watchdog_fault_oe(link.watchdog_fault_oe),
        .manual_reset_in_n(link.manual_reset_in_n), .watchdog_kick_in(link.watchdog_kick_in));

    // free-running clock
    always #20 hclk = ~hclk;

    task automatic conclude;
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard and cycle count
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (exp !== got) begin
            $display("ERROR %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic rng(input string what, input int v, input int lo, input int hi);
        checked++;
        if (v < lo || v > hi) begin
            $display("ERROR %s expected %0d..%0d seen %0d", what, lo, hi, v);
            n_errors++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // one single transfer; waits on hready for both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // k: 0..2 rails, 3 window low, 4 window high (inverted)
    task automatic set_good(input int k, input logic good);
        @(posedge hclk);
        case (k)
            0: rail1_sense <= good;
            1: rail2_sense <= good;
            2: rail3_sense <= good;
            3: window_low_sense <= good;
            default: window_high_sense <= ~good;
        endcase
    endtask

    task automatic wait_rel(input int ch);
        t0 = cyc;
        while (link.channel_reset_out_n[ch] !== 1'b1) tick(1);
        d = cyc - t0;
    endtask

    task automatic t_release;
        int ord [4] = '{0, 2, 3, 1};
        check("pins after reset", 32'h0, link.channel_reset_out_n);
        t0 = cyc;
        foreach (ord[i]) begin
            while (link.channel_reset_out_n[ord[i]] !== 1'b1) tick(1);
            rng("powerup delay", cyc - t0, TDLY[ord[i]], TDLY[ord[i]] + 5);
        end
    endtask

    task automatic t_chan;
        int ch;
        for (int k = 1; k < 5; k++) begin
            ch = (k < 4) ? k : 3;
            set_good(k, 1'b0);
            tick(4);
            check("assert", 32'h0, link.channel_reset_out_n[ch]);
            set_good(k, 1'b1);
            tick(8);
            set_good(k, 1'b0);
            set_good(k, 1'b1);
            wait_rel(ch);
            rng("release", d, TDLY[ch], TDLY[ch] + 5);
        end
    endtask

    task automatic t_primary;
        set_good(0, 1'b0);
        tick(4);
        check("rail1 low", 32'h0, link.primary_reset_out_n);
        set_good(0, 1'b1);
        ahb(1'b1, RSW_CTRL_OFS, 32'h1);
        tick(40);
        ahb(1'b0, RSW_STATUS_OFS, 32'h0);
        check("status", 32'h21, rd & 32'h3f);
        ahb(1'b1, RSW_CTRL_OFS, 32'h0);
        wait_rel(0);
        rng("manual release", d, SHORT, SHORT + 5);
    endtask

    task automatic t_wdog;
        ahb(1'b0, RSW_IRQ_STAT_OFS, 32'h0);
        ahb(1'b1, RSW_IRQ_MASK_OFS, 32'h10);
        ahb(1'b1, RSW_CTRL_OFS, 32'h1);
        tick(TMO + 20);
        check("fault held", 32'h1, link.watchdog_fault_out_n);
        ahb(1'b1, RSW_CTRL_OFS, 32'h0);
        wait_rel(0);
        repeat (4) begin
            tick(200);
            ahb(1'b1, RSW_KICK_OFS, 32'h0);
        end
        check("kicked", 32'h1, link.watchdog_fault_out_n);
        check("irq idle", 32'h0, irq);
        t0 = cyc;
        while (link.watchdog_fault_out_n !== 1'b0) tick(1);
        rng("timeout", cyc - t0, TMO, TMO + 8);
        tick(1);
        check("irq fault", 32'h1, irq);
        ahb(1'b0, RSW_IRQ_STAT_OFS, 32'h0);
        check("irq stat", 32'h10, rd & 32'h10);
        tick(1);
        check("irq cleared", 32'h0, irq);
        repeat (2) ahb(1'b1, RSW_KICK_OFS, 32'h0);
        tick(10);
        check("latched", 32'h0, link.watchdog_fault_out_n);
        ahb(1'b1, RSW_CTRL_OFS, 32'h1);
        tick(4);
        check("fault clear", 32'h1, link.watchdog_fault_out_n);
        ahb(1'b1, RSW_CTRL_OFS, 32'h0);
        wait_rel(0);
    endtask

    task automatic t_legacy;
        ahb(1'b1, RSW_CTRL_OFS, 32'h2);
        while (link.watchdog_fault_out_n !== 1'b0) tick(1);
        tick(6);
        check("legacy fault", 32'h1, link.watchdog_fault_out_n);
        check("legacy primary", 32'h0, link.primary_reset_out_n);
        ahb(1'b1, RSW_CTRL_OFS, 32'h0);
        wait_rel(0);
        rng("legacy release", d, 0, SHORT + 5);
    endtask

    task automatic t_irq;
        ahb(1'b0, RSW_IRQ_STAT_OFS, 32'h0);
        ahb(1'b1, RSW_IRQ_MASK_OFS, 32'h0);
        set_good(1, 1'b0);
        tick(5);
        check("irq masked", 32'h0, irq);
        ahb(1'b1, RSW_IRQ_MASK_OFS, 32'h2);
        tick(1);
        check("irq unmasked", 32'h1, irq);
        ahb(1'b0, RSW_IRQ_STAT_OFS, 32'h0);
        check("irq event", 32'h2, rd & 32'h2);
        tick(1);
        check("irq read clear", 32'h0, irq);
        set_good(1, 1'b1);
        ahb(1'b1, 8'h20, 32'hffffffff);
        ahb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h0, rd);
        ahb(1'b0, RSW_IRQ_MASK_OFS, 32'h0);
        check("mask", 32'h2, rd);
        check("hresp", 32'h0, hresp);
    endtask

    // stimulus sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        {rail1_sense, rail2_sense, rail3_sense, window_low_sense} = 4'hf;
        window_high_sense = 1'b0;
        dsel[0] = RSW_DLY_SHORT;
        dsel[1] = RSW_DLY_LONG;
        dsel[2] = RSW_DLY_PROG;
        dsel[3] = RSW_DLY_PROG;
        prog = '0;
        prog[2] = 25'h1e;
        prog[3] = 25'h28;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        {n_errors, checked, cyc} = '0;
        tick(4);
        check("irq in reset", 32'h0, irq);
        @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        t_release();
        t_chan();
        t_primary();
        t_wdog();
        t_legacy();
        t_irq();
        conclude();
    end
endmodule
